// ---- test/spu_core_tb.sv ----
// Self-checking bench for the serial port core
`timescale 1ns/1ns
`default_nettype none
module spu_core_tb;
  logic       clock;
  logic       sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  logic       sfr_wr = 1'b0, sfr_rd = 1'b0, bit_wr = 1'b0, bit_rd = 1'b0;
  logic       bit_wdata = 1'b0, ext_os_tick = 1'b0, double_rate = 1'b0;
  logic [7:0] sfr_rdata;
  logic       bit_rdata, rxd_out, rxd_oe, txd_out;
  wire logic  rem_rxd;
  // Pin level: core drives it only in shift mode
  wire logic  rxd_w = rxd_oe ? rxd_out : rem_rxd;
  int         error_cnt = 0;
  int         n_checks  = 0;
  int         f0;
  time        t1;
  logic [7:0] v;
  logic [1:0] md;
  logic       nb8;
  logic [7:0] ra[5]   = '{8'h98, 8'h99, 8'h9D, 8'h9E, 8'hA0};
  logic [1:0] tmode[4] = '{2'h1, 2'h2, 2'h2, 2'h3};
  logic [7:0] tdat[4]  = '{8'hA5, 8'h3C, 8'hC6, 8'h81};
  logic [7:0] rctl[7]  = '{8'h50, 8'h70, 8'h50, 8'hB0, 8'hF0, 8'hD0, 8'hC0};
  logic [8:0] rdat[7]  = '{9'h0A5, 9'h03C, 9'h0C3, 9'h15A, 9'h0E1, 9'h01E, 9'h1FF};
  logic [6:0] rstp     = 7'b1111001;
  logic [6:0] racc     = 7'b0101101;

  spu_core #(.RXQ_DEPTH(2)) spu_core_i (
    .clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata),
    .bit_rdata(bit_rdata), .ext_os_tick(ext_os_tick), .double_rate(double_rate),
    .rxd_in(rxd_w), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
  spu_remote spu_remote_i (.clock(clock), .txd(txd_out), .rxd(rem_rxd));

  // 250 MHz core clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Oversample tick every other cycle, so a variable-rate bit is 32 clocks
  always @(posedge clock) ext_os_tick <= ~ext_os_tick;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr    <= 1'b0;
  endtask
  // Read data is registered, so it is taken just after the read edge
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clock);
    sfr_rd   <= 1'b0;
    #1 chk(sfr_rdata, exp);
  endtask
  task automatic bwr(input logic [7:0] a, input logic d);
    @(posedge clock);
    bit_addr  <= a;
    bit_wdata <= d;
    bit_wr    <= 1'b1;
    @(posedge clock);
    bit_wr    <= 1'b0;
  endtask
  task automatic brc(input logic [7:0] a, input logic exp);
    @(posedge clock);
    bit_addr <= a;
    bit_rd   <= 1'b1;
    @(posedge clock);
    bit_rd   <= 1'b0;
    #1 chk(8'(bit_rdata), 8'(exp));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    cyc(20000);
    error_cnt++;
    results();
  end

  initial begin
    cyc(20);
    sys_rst <= 1'b0;
    // Reset values, unmapped byte and bit places read as zero
    foreach (ra[i]) rc(ra[i], 8'h00);
    for (int i = 0; i < 9; i++) brc(8'(8'h98 + i), 1'b0);
    bwr(8'h9B, 1'b1);
    bwr(8'h9D, 1'b1);
    rc(8'h98, 8'h28);
    brc(8'h9D, 1'b1);
    wr(8'h9D, 8'h5A);
    wr(8'h9E, 8'h3C);
    rc(8'h9D, 8'h5A);
    rc(8'h9E, 8'h3C);
    // Shift mode; filter enable kept clear here
    wr(8'h98, 8'h00);
    wr(8'h99, 8'h96);
    // Enable is looked at in the low half; it drops on the last rising edge
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_out);
      chk(8'(rxd_oe), 8'h01);
      @(posedge txd_out);
      if (i == 0) t1 = $time;
      v[i] = rxd_out;
      if (i == 4) rc(8'h98, 8'h00);
    end
    chk(8'(($time - t1) / 4), 8'h54);
    chk(v, 8'h96);
    cyc(8);
    rc(8'h98, 8'h02);
    rc(8'h99, 8'h00);
    cyc(50);
    brc(8'h99, 1'b1);
    bwr(8'h99, 1'b0);
    brc(8'h99, 1'b0);
    // Async transmit: mode 01, mode 10 at both rates, mode 11
    spu_remote_i.listen = 1'b1;
    for (int i = 0; i < 4; i++) begin
      md = tmode[i];
      @(posedge clock) double_rate <= (i == 1);
      spu_remote_i.blen = (i == 1) ? 16 : 32;
      spu_remote_i.nb = (md == 2'h1) ? 8 : 9;
      f0 = spu_remote_i.frames;
      wr(8'h98, {md, 2'b00, i[0], 3'b000});
      wr(8'h99, tdat[i]);
      cyc(60);
      rc(8'h98, {md, 2'b00, i[0], 3'b000});
      wait (spu_remote_i.frames != f0);
      chk(spu_remote_i.got[7:0], tdat[i]);
      if (md != 2'h1) chk(8'(spu_remote_i.got[8]), 8'(i[0]));
      chk(8'(spu_remote_i.stop_got), 8'h01);
      rc(8'h98, {md, 2'b00, i[0], 3'b010});
      // Let the stop bit finish; a write while busy is ignored
      cyc(40);
    end
    // Receive: filter, stop or ninth bit capture, receive enable
    @(posedge clock) double_rate <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      md = rctl[i][7:6];
      spu_remote_i.blen = (md == 2'h2) ? 16 : 32;
      spu_remote_i.nb = (md == 2'h1) ? 8 : 9;
      wr(8'h98, rctl[i]);
      spu_remote_i.send(rdat[i], rstp[i], 8);
      cyc(30);
      nb8 = (md == 2'h1) ? rstp[i] : rdat[i][8];
      rc(8'h98, rctl[i] | (racc[i] ? {5'b0, nb8, 2'b01} : 8'h00));
      if (racc[i]) rc(8'h99, rdat[i][7:0]);
    end
    // Overrun: second frame arrives while the first is unread
    spu_remote_i.blen = 16;
    spu_remote_i.nb = 9;
    wr(8'h9E, 8'h00);
    wr(8'h98, 8'h90);
    spu_remote_i.send(9'h011, 1'b1, 8);
    spu_remote_i.send(9'h022, 1'b1, 4);
    cyc(30);
    rc(8'h9E, 8'h80);
    rc(8'h99, 8'h11);
    bwr(8'h98, 1'b0);
    cyc(4);
    brc(8'h98, 1'b1);
    rc(8'h99, 8'h22);
    wr(8'h9E, 8'h00);
    rc(8'h9E, 8'h00);
    // Shift-mode reception from the idle-high pin gives all ones
    spu_remote_i.listen = 1'b0;
    wr(8'h98, 8'h10);
    cyc(110);
    rc(8'h98, 8'h11);
    rc(8'h99, 8'hFF);
    results();
  end
endmodule // spu_core_tb
`default_nettype wire

// ---- test/spu_remote.sv ----
// Remote serial device model on the receive and transmit pins
`timescale 1ns/1ns
`default_nettype none
module spu_remote (
  // Clock
  input  wire logic clock,
  // Pins
  input  wire logic txd,
  output logic      rxd
);
  int         blen   = 32;
  int         nb     = 9;
  logic       listen = 1'b0;
  int         frames = 0;
  logic [8:0] got    = 9'h000;
  logic       stop_got;

  // Frame capture at mid-bit; listen gates out the shift-mode clock on txd
  initial forever begin
    @(negedge txd);
    if (listen) begin
      repeat (blen / 2) @(posedge clock);
      for (int i = 0; i < nb; i++) begin
        repeat (blen) @(posedge clock);
        got[i] = txd;
      end
      repeat (blen) @(posedge clock);
      stop_got = txd;
      frames++;
    end
  end

  // Idle line is high, as a pulled-up receive pin would be
  initial rxd = 1'b1;

  // One frame; gap sets how promptly the far end answers
  task automatic send(input logic [8:0] d, input logic stp, input int gap);
    repeat (gap) @(posedge clock);
    rxd <= 1'b0;
    repeat (blen) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (blen) @(posedge clock);
    end
    rxd <= stp;
    repeat (blen) @(posedge clock);
    rxd <= 1'b1;
  endtask
endmodule // spu_remote
`default_nettype wire

// ---- verilog/spu_core.sv ----
// Serial port: control, data buffer, shift-register and UART engines
//
// Notes on behaviour
// - Mode 00: synchronous shift register at core clock divided by twelve.
// - Mode 01: eight-bit asynchronous link, rate from the core timer tick.
// - Mode 10: nine-bit asynchronous link at core clock over 32 or 16.
// - Mode 11: nine-bit asynchronous link, rate from the core timer tick.
// - Mode 01 with filter on: receive flag only after a valid stop bit.
// - Nine-bit modes with filter on: no receive flag when ninth bit is 0.
// - Reception starts only while receive enable is set; clearing it stops only the asynchronous receiver.
// - Nine-bit modes send the transmit ninth bit as ninth data bit.
// - Nine-bit modes latch the received ninth bit into its status bit.
// - Mode 01 stores the received stop bit in that status bit.
// - Transmit flag: end of eighth bit in shift mode, stop start else.
// - Receive flag: end of eighth bit, or mid stop bit; software clears.
// - Control bits reachable singly at bit addresses 0x98 to 0x9F.
// - Data buffer resets to zero and is byte access only.
// - Writing data loads transmitter; reading returns separate receive byte.
// - Received bytes are buffered while the next one arrives.
// - New character while receive flag set raises overrun; write 0 clears.
`timescale 1ns/1ns
`default_nettype none
`include "spu_defs.svh"
module spu_core #(
  parameter int unsigned RXQ_DEPTH = 2
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Special-function byte port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic [7:0]      sfr_rdata,
  // Bit-addressable port
  input  wire logic [7:0] bit_addr,
  input  wire logic       bit_wr,
  input  wire logic       bit_rd,
  input  wire logic       bit_wdata,
  output logic            bit_rdata,
  // Rate sources
  input  wire logic       ext_os_tick,
  input  wire logic       double_rate,
  // Serial pins
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe,
  output logic            txd_out
);
  import spu_pkg::*;

  if (RXQ_DEPTH < 2) begin : g_chk
    $error("spu_core needs RXQ_DEPTH >= 2");
  end

  spu_core_st_t q;
  spu_core_st_t d;

  logic [1:0] mode;
  logic       rs;
  logic       os_tick;
  logic       half_tick;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [8:0] buf_data;
  logic       fire;
  logic       ti_set;
  logic       push_new;
  logic       owe_set;
  logic       wr_ctrl;
  logic       bhit;
  logic       sw_ctrl_wr;
  logic       tx_go;
  logic       m0_rx_go;
  logic [7:0] ctrl_n;
  logic [8:0] new_data;
  logic       new_ok;

  // Data bits per frame for the current mode
  function automatic logic [3:0] data_bits(input logic [1:0] m);
    data_bits = (m == `SPU_MODE_8V) ? 4'(`SPU_DATA8) : 4'(`SPU_DATA9);
  endfunction

  // Bit address lands inside serial_control
  function automatic logic bit_hit(input logic [7:0] a);
    bit_hit = (a[7:3] == 5'(`SPU_BIT_BASE >> 3));
  endfunction

  assign mode = q.ctrl[`SPU_MODE_MSB:`SPU_MODE_LSB];
  assign rs = q.rsync[1];

  spu_rate_gen u_rate (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .mode        (mode),
    .double_rate (double_rate),
    .ext_os_tick (ext_os_tick),
    .os_tick     (os_tick),
    .half_tick   (half_tick)
  );

  // Receive buffer drains only while the receive flag is clear
  spu_rx_buf #(.W(9), .DEPTH(RXQ_DEPTH)) u_rxq (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (q.push),
    .in_ready  (buf_in_ready),
    .in_data   (q.push_data),
    .out_valid (buf_out_valid),
    .out_ready (!q.ctrl[`SPU_RI]),
    .out_data  (buf_data)
  );

  // Next-state logic for the whole port
  always_comb begin
    d = q;
    ti_set = 1'b0;
    push_new = 1'b0;
    owe_set = 1'b0;
    new_data = 9'h000;
    new_ok = 1'b0;
    fire = buf_out_valid && !q.ctrl[`SPU_RI];
    wr_ctrl = sfr_wr && (sfr_addr == `SPU_ADDR_CTRL);
    bhit = bit_hit(bit_addr);
    sw_ctrl_wr = wr_ctrl || (bit_wr && bhit);
    tx_go = sfr_wr && (sfr_addr == `SPU_ADDR_DATA) && !q.tx_busy;
    m0_rx_go = (mode == `SPU_MODE_SHIFT) && q.ctrl[`SPU_REN] && !q.ctrl[`SPU_RI]
               && !q.tx_busy && !tx_go && buf_in_ready && !q.push;

    // Pin synchroniser, second stage feeds all logic
    d.rsync = {q.rsync[0], rxd_in};
    d.rprev = q.rsync[1];

    // Pending push leaves once the buffer takes it
    if (q.push && buf_in_ready) begin
      d.push = 1'b0;
    end

    // Transmit load; the shift mode also clocks reception
    if (tx_go) begin
      d.tx_busy = 1'b1;
      d.tx_os = 4'h0;
      if (mode == `SPU_MODE_SHIFT) begin
        d.tx_m0 = 1'b1;
        d.tx_m0rx = 1'b0;
        d.tx_ph = 1'b0;
        d.tx_sh = {3'h7, sfr_wdata};
        d.tx_left = 4'(`SPU_M0_BITS);
        d.rxd_o = sfr_wdata[0];
        d.rxd_oe = 1'b1;
      end else begin
        d.tx_m0 = 1'b0;
        d.tx_sh = {1'b1, (mode == `SPU_MODE_8V) ? 1'b1 : q.ctrl[`SPU_TB8],
                   sfr_wdata, 1'b0};
        d.tx_left = data_bits(mode) + 4'h2;
        d.txd = 1'b0;
      end
    end else if (m0_rx_go) begin
      d.tx_busy = 1'b1;
      d.tx_m0 = 1'b1;
      d.tx_m0rx = 1'b1;
      d.tx_ph = 1'b0;
      d.tx_left = 4'(`SPU_M0_BITS);
      d.rxd_oe = 1'b0;
    end else if (q.tx_busy && q.tx_m0 && half_tick) begin
      // Shift mode: clock low half drives data, rising half samples
      if (!q.tx_ph) begin
        d.txd = 1'b0;
        d.tx_ph = 1'b1;
        if (!q.tx_m0rx) begin
          d.rxd_o = q.tx_sh[0];
        end
      end else begin
        d.txd = 1'b1;
        d.tx_ph = 1'b0;
        d.tx_left = q.tx_left - 4'h1;
        if (q.tx_m0rx) begin
          d.rx_sh[7:0] = {rs, q.rx_sh[7:1]};
        end else begin
          d.tx_sh = {1'b1, q.tx_sh[10:1]};
        end
        if (q.tx_left == 4'h1) begin
          d.tx_busy = 1'b0;
          d.tx_m0 = 1'b0;
          d.rxd_oe = 1'b0;
          if (q.tx_m0rx) begin
            push_new = 1'b1;
            new_ok = 1'b1;
            new_data = {q.ctrl[`SPU_RB8], rs, q.rx_sh[7:1]};
          end else begin
            ti_set = 1'b1;
          end
        end
      end
    end else if (q.tx_busy && !q.tx_m0 && os_tick) begin
      // Asynchronous transmit, sixteen ticks per bit
      d.tx_os = q.tx_os + 4'h1;
      if (q.tx_os == 4'(`SPU_OS - 1)) begin
        d.tx_os = 4'h0;
        if (q.tx_left == 4'h1) begin
          d.tx_busy = 1'b0;
        end else begin
          d.tx_sh = {1'b1, q.tx_sh[10:1]};
          d.txd = q.tx_sh[1];
          d.tx_left = q.tx_left - 4'h1;
          if (q.tx_left == 4'h2) begin
            ti_set = 1'b1;
          end
        end
      end
    end

    // Asynchronous receiver, samples at bit centres
    unique case (q.rx_st)
      SPU_RX_IDLE: begin
        if (mode != `SPU_MODE_SHIFT && q.ctrl[`SPU_REN] && q.rprev && !rs
            && buf_in_ready && !q.push) begin
          d.rx_st = SPU_RX_START;
          d.rx_os = 4'h0;
        end
      end
      SPU_RX_START: begin
        if (os_tick) begin
          d.rx_os = q.rx_os + 4'h1;
          if (q.rx_os == 4'(`SPU_OS_MID - 1)) begin
            d.rx_os = 4'h0;
            d.rx_cnt = 4'h0;
            // A glitch shorter than half a bit is not a start
            d.rx_st = rs ? SPU_RX_IDLE : SPU_RX_BITS;
          end
        end
      end
      SPU_RX_BITS: begin
        if (os_tick) begin
          d.rx_os = q.rx_os + 4'h1;
          if (q.rx_os == 4'(`SPU_OS - 1)) begin
            d.rx_os = 4'h0;
            if (q.rx_cnt == data_bits(mode)) begin
              d.rx_st = SPU_RX_IDLE;
              push_new = 1'b1;
              if (mode == `SPU_MODE_8V) begin
                new_data = {rs, q.rx_sh[8:1]};
                new_ok = !q.ctrl[`SPU_SM2] || rs;
              end else begin
                new_data = q.rx_sh;
                new_ok = !q.ctrl[`SPU_SM2] || q.rx_sh[8];
              end
            end else begin
              d.rx_sh = {rs, q.rx_sh[8:1]};
              d.rx_cnt = q.rx_cnt + 4'h1;
            end
          end
        end
      end
      default: d.rx_st = SPU_RX_IDLE;
    endcase
    if (!q.ctrl[`SPU_REN] || mode == `SPU_MODE_SHIFT) begin
      d.rx_st = SPU_RX_IDLE;
    end

    // Completed character goes to the receive buffer
    if (push_new && new_ok) begin
      d.push = 1'b1;
      d.push_data = new_data;
      owe_set = q.ctrl[`SPU_RI];
    end

    // Control register: software first, hardware sets win
    ctrl_n = q.ctrl;
    if (wr_ctrl) begin
      ctrl_n = sfr_wdata;
    end
    if (bit_wr && bhit) begin
      ctrl_n[bit_addr[2:0]] = bit_wdata;
    end
    if (fire) begin
      ctrl_n[`SPU_RB8] = buf_data[8];
      ctrl_n[`SPU_RI] = 1'b1;
      d.rxhold = buf_data[7:0];
    end
    if (ti_set) begin
      ctrl_n[`SPU_TI] = 1'b1;
    end
    d.ctrl = ctrl_n;

    // Side registers; overrun clears only by writing 0
    if (sfr_wr && sfr_addr == `SPU_ADDR_FRAC) begin
      d.frac = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == `SPU_ADDR_RATE) begin
      d.rate = sfr_wdata;
      d.rate[`SPU_OWE] = q.rate[`SPU_OWE] & sfr_wdata[`SPU_OWE];
    end
    if (owe_set) begin
      d.rate[`SPU_OWE] = 1'b1;
    end

    // Read data, registered; unmapped addresses read zero
    if (sfr_rd) begin
      unique case (sfr_addr)
        `SPU_ADDR_CTRL: d.rdata = q.ctrl;
        `SPU_ADDR_DATA: d.rdata = q.rxhold;
        `SPU_ADDR_FRAC: d.rdata = q.frac;
        `SPU_ADDR_RATE: d.rdata = q.rate;
        default:        d.rdata = 8'h00;
      endcase
    end
    if (bit_rd) begin
      d.bit_rdata = bhit && q.ctrl[bit_addr[2:0]];
    end
  end

  // State register; line idles high
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
      q.txd <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata = q.rdata;
  assign bit_rdata = q.bit_rdata;
  assign rxd_out = q.rxd_o;
  assign rxd_oe = q.rxd_oe;
  assign txd_out = q.txd;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_reset;
    @(posedge clock) disable iff (1'b0)
      sys_rst |=> q.ctrl == `SPU_CTRL_RST && q.rxhold == `SPU_DATA_RST && txd_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_ti_stop;
    ti_set && mode != `SPU_MODE_SHIFT |=> txd_out && q.ctrl[`SPU_TI] && q.tx_busy;
  endproperty
  a_ti_stop: assert property (p_ti_stop) else $error("tx flag not at stop bit");

  property p_ti_hold;
    q.ctrl[`SPU_TI] && !sw_ctrl_wr |=> q.ctrl[`SPU_TI];
  endproperty
  a_ti_hold: assert property (p_ti_hold) else $error("tx flag dropped by hardware");

  property p_start;
    tx_go && mode != `SPU_MODE_SHIFT |=> !txd_out ##1 !txd_out;
  endproperty
  a_start: assert property (p_start) else $error("start bit not low");

  property p_ren;
    !q.ctrl[`SPU_REN] |=> q.rx_st == SPU_RX_IDLE;
  endproperty
  a_ren: assert property (p_ren) else $error("receiving while disabled");

  property p_sm2_9;
    push_new && new_ok && q.ctrl[`SPU_SM2] && mode[1] |=> q.push && q.push_data[8];
  endproperty
  a_sm2_9: assert property (p_sm2_9) else $error("filtered frame accepted");

  property p_sm2_8;
    push_new && mode == `SPU_MODE_8V && q.ctrl[`SPU_SM2] && !rs |=> !q.push;
  endproperty
  a_sm2_8: assert property (p_sm2_8) else $error("bad stop bit accepted");

  property p_drain;
    fire |=> q.ctrl[`SPU_RI] && q.rxhold == $past(buf_data[7:0])
             && q.ctrl[`SPU_RB8] == $past(buf_data[8]);
  endproperty
  a_drain: assert property (p_drain) else $error("receive byte not delivered");

  property p_tb8;
    tx_go && mode[1] |=> q.tx_sh[9] == $past(q.ctrl[`SPU_TB8]);
  endproperty
  a_tb8: assert property (p_tb8) else $error("ninth tx bit wrong");

  property p_owe;
    push_new && new_ok && q.ctrl[`SPU_RI] |=> q.rate[`SPU_OWE];
  endproperty
  a_owe: assert property (p_owe) else $error("overrun not flagged");

  property p_read;
    sfr_rd && sfr_addr == `SPU_ADDR_DATA |=> sfr_rdata == $past(q.rxhold);
  endproperty
  a_read: assert property (p_read) else $error("data read not receive byte");

  c_tx_done: cover property (ti_set && mode == `SPU_MODE_9V);
  c_m0_rx: cover property (push_new && mode == `SPU_MODE_SHIFT);
  c_overrun: cover property (owe_set);
  c_buf_full: cover property (!buf_in_ready);

endmodule // spu_core
`default_nettype wire

// ---- verilog/spu_defs.svh ----
// Register map, field positions and rate ratios of the serial port
`ifndef SPU_DEFS_SVH
`define SPU_DEFS_SVH

// Byte addresses on the special-function bus
`define SPU_ADDR_CTRL 8'h98
`define SPU_ADDR_DATA 8'h99
`define SPU_ADDR_FRAC 8'h9D
`define SPU_ADDR_RATE 8'h9E

// Bit addresses of serial_control span 0x98..0x9F
`define SPU_BIT_BASE 8'h98

// Reset values
`define SPU_CTRL_RST 8'h00
`define SPU_DATA_RST 8'h00
`define SPU_FRAC_RST 8'h00
`define SPU_RATE_RST 8'h00

// serial_control fields
`define SPU_RI       0
`define SPU_TI       1
`define SPU_RB8      2
`define SPU_TB8      3
`define SPU_REN      4
`define SPU_SM2      5
`define SPU_MODE_LSB 6
`define SPU_MODE_MSB 7

// baud_rate_control overrun flag
`define SPU_OWE 7

// Mode select encodings
`define SPU_MODE_SHIFT 2'h0
`define SPU_MODE_8V    2'h1
`define SPU_MODE_9F    2'h2
`define SPU_MODE_9V    2'h3

// Rate ratios: shift mode bit = core/12, fixed 9-bit = core/32 or core/16
`define SPU_M0_DIV      12
`define SPU_M0_HALF     (`SPU_M0_DIV / 2)
`define SPU_OS          16
`define SPU_OS_MID      (`SPU_OS / 2)
`define SPU_M2_SLOW_DIV 32
`define SPU_M2_FAST_DIV 16

// Frame sizes
`define SPU_M0_BITS 8
`define SPU_DATA8   8
`define SPU_DATA9   9

`endif

// ---- verilog/spu_pkg.sv ----
// Types shared by the serial port modules
`default_nettype none
package spu_pkg;

  // Asynchronous receiver states
  typedef enum logic [1:0] {
    SPU_RX_IDLE,
    SPU_RX_START,
    SPU_RX_BITS
  } spu_rx_st_t;

  // Rate generator state
  typedef struct packed {
    logic [3:0] cnt;
    logic       os;
    logic       half;
  } spu_rate_st_t;

  // Serial port state
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  rxhold;
    logic [7:0]  frac;
    logic [7:0]  rate;
    logic [7:0]  rdata;
    logic        bit_rdata;
    logic        tx_busy;
    logic        tx_m0;
    logic        tx_m0rx;
    logic        tx_ph;
    logic [10:0] tx_sh;
    logic [3:0]  tx_left;
    logic [3:0]  tx_os;
    spu_rx_st_t  rx_st;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic [3:0]  rx_os;
    logic [1:0]  rsync;
    logic        rprev;
    logic        push;
    logic [8:0]  push_data;
    logic        txd;
    logic        rxd_o;
    logic        rxd_oe;
  } spu_core_st_t;

endpackage
`default_nettype wire

// ---- verilog/spu_rate_gen.sv ----
// Bit-rate tick generator for the fixed-rate modes
`timescale 1ns/1ns
`default_nettype none
`include "spu_defs.svh"
module spu_rate_gen (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Rate selection
  input  wire logic [1:0] mode,
  input  wire logic       double_rate,
  input  wire logic       ext_os_tick,
  // Ticks
  output logic            os_tick,
  output logic            half_tick
);
  import spu_pkg::*;

  spu_rate_st_t q;
  spu_rate_st_t d;
  logic [3:0]   lim;

  // Divider: half-bit ticks in shift mode, 16x ticks otherwise
  always_comb begin
    d = q;
    d.os = 1'b0;
    d.half = 1'b0;
    lim = double_rate ? 4'(`SPU_M2_FAST_DIV / `SPU_OS - 1)
                      : 4'(`SPU_M2_SLOW_DIV / `SPU_OS - 1);
    if (mode == `SPU_MODE_SHIFT) begin
      if (q.cnt >= 4'(`SPU_M0_HALF - 1)) begin
        d.cnt = 4'h0;
        d.half = 1'b1;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end else if (mode == `SPU_MODE_9F) begin
      if (q.cnt >= lim) begin
        d.cnt = 4'h0;
        d.os = 1'b1;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end else begin
      // Variable rate comes from the core timer
      d.cnt = 4'h0;
      d.os = ext_os_tick;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign os_tick = q.os;
  assign half_tick = q.half;

  property p_m0_rate;
    @(posedge clock) disable iff (sys_rst || mode != `SPU_MODE_SHIFT)
      q.half |=> !q.half [*5] ##1 q.half;
  endproperty
  a_m0_rate: assert property (p_m0_rate) else $error("shift half-bit not 6 clocks");

  property p_m2_fast;
    @(posedge clock) disable iff (sys_rst)
      (mode == `SPU_MODE_9F && double_rate) [*3] |-> q.os;
  endproperty
  a_m2_fast: assert property (p_m2_fast) else $error("fast fixed rate tick missing");

endmodule // spu_rate_gen
`default_nettype wire

// ---- verilog/spu_rx_buf.sv ----
// Small receive FIFO between the receiver and the data register
`timescale 1ns/1ns
`default_nettype none
module spu_rx_buf #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import spu_pkg::*;

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || W < 1) begin : g_chk
    $error("spu_rx_buf needs DEPTH >= 2 and W >= 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } spu_buf_st_t;

  spu_buf_st_t q;
  spu_buf_st_t d;
  logic        win;
  logic        rin;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];

  // Pointers wrap; count gives honest full and empty
  always_comb begin
    d = q;
    win = in_valid && in_ready;
    rin = out_valid && out_ready;
    if (win) begin
      d.mem[q.wp] = in_data;
      d.wp = nxt(q.wp);
    end
    if (rin) begin
      d.rp = nxt(q.rp);
    end
    d.cnt = q.cnt + CW'(win) - CW'(rin);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // spu_rx_buf
`default_nettype wire
